// File: shared/fmag_pkg.sv
package fmag_pkg;
  // widths
  localparam int ADDR_W   = 32;
  localparam int COORD_W  = 16;
  localparam int RADDR_W  = 4;
  localparam int RDATA_W  = 32;
  // channel blocking
  localparam int BLK_CH       = 16;
  localparam int BLK_SHIFT    = 4;
  localparam int BLK_ALIGN    = 16;
  localparam int BLK_ALIGN_LSB = 4;
  // element sizes in bytes
  localparam logic [1:0] ESZ_ONE = 2'h1;
  localparam logic [1:0] ESZ_TWO = 2'h2;
  // batch count is fixed
  localparam int BATCH_COUNT = 1;
  // register offsets (word index)
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_SRC_FEATURE_MAP_START_ADDRESS  = 4'h1;
  localparam logic [3:0] REG_SRC_SY    = 4'h2;
  localparam logic [3:0] REG_SRC_SX    = 4'h3;
  localparam logic [3:0] REG_SRC_SC    = 4'h4;
  localparam logic [3:0] REG_DST_FEATURE_MAP_START_ADDRESS  = 4'h5;
  localparam logic [3:0] REG_DST_SY    = 4'h6;
  localparam logic [3:0] REG_DST_SX    = 4'h7;
  localparam logic [3:0] REG_DST_SC    = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'h9;
  localparam logic [3:0] REG_KSTRIDE   = 4'hA;
  // ctrl field positions
  localparam int CTRL_SRC_BLK = 0;
  localparam int CTRL_DST_BLK = 1;
  localparam int CTRL_ESZ2    = 2;
  localparam int CTRL_TILE_LO = 4;
  localparam int CTRL_TILE_W  = 2;
  // status field positions
  localparam int ST_SRC_ALIGN = 0;
  localparam int ST_DST_ALIGN = 1;
  localparam int ST_TILE_ERR  = 2;
  localparam int ST_BUSY      = 3;
  localparam logic [RDATA_W-1:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic { LAYOUT_HWC, LAYOUT_CB16 } fmag_layout_type;

  // one mapping descriptor
  typedef struct packed {
    fmag_layout_type   layout;
    logic [ADDR_W-1:0] feature_map_start_address;
    logic [ADDR_W-1:0] stride_y;
    logic [ADDR_W-1:0] stride_x;
    logic [ADDR_W-1:0] stride_c;
  } fmag_map_type;

  // element coordinate request
  typedef struct packed {
    logic [COORD_W-1:0] y;
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] c;
  } fmag_coord_type;
endpackage

// File: src/fmag_addr_calc.sv
`timescale 1ns/1ps
module fmag_addr_calc (
  // descriptor and element
  input  wire fmag_pkg::fmag_map_type   map,
  input  wire fmag_pkg::fmag_coord_type crd,
  input  wire logic                     esz2,
  // result
  output logic [fmag_pkg::ADDR_W-1:0]   addr,
  output logic                          misaligned
);
  localparam int AW = fmag_pkg::ADDR_W;
  // channel split by low four bits
  wire [AW-1:0] c_blk = AW'(crd.c >> fmag_pkg::BLK_SHIFT);
  wire [AW-1:0] c_in  = AW'(crd.c[fmag_pkg::BLK_SHIFT-1:0]);
  wire [AW-1:0] yy    = AW'(crd.y);
  wire [AW-1:0] xx    = AW'(crd.x);
  wire [AW-1:0] cc    = AW'(crd.c);
  // byte scaling by element size
  wire [AW-1:0] off_hwc = esz2 ? (cc << 1) : cc;
  wire [AW-1:0] cb_lin  = AW'((xx << fmag_pkg::BLK_SHIFT) + c_in);
  wire [AW-1:0] off_cb  = esz2 ? (cb_lin << 1) : cb_lin;
  wire [AW-1:0] a_hwc = AW'(map.feature_map_start_address + AW'(yy * map.stride_y) + AW'(xx * map.stride_x) + off_hwc);
  wire [AW-1:0] a_cb  = AW'(map.feature_map_start_address + AW'(yy * map.stride_y) + AW'(c_blk * map.stride_c) + off_cb);
  // alignment of programmed values
  wire mis_hwc = esz2 & (map.feature_map_start_address[0] | map.stride_y[0] | map.stride_x[0]);
  wire mis_cb  = |{map.feature_map_start_address[3:0], map.stride_y[3:0], map.stride_c[3:0]};
  // layout select
  assign addr       = (map.layout == fmag_pkg::LAYOUT_CB16) ? a_cb : a_hwc;
  assign misaligned = (map.layout == fmag_pkg::LAYOUT_CB16) ? mis_cb : mis_hwc;
endmodule

// File: src/fmag_top.sv
`timescale 1ns/1ps
module fmag_top #(
  parameter int PACK_DEPTH = 4
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           clk_en,
  // register port
  input  wire logic [fmag_pkg::RADDR_W-1:0]   reg_addr,
  input  wire logic [fmag_pkg::RDATA_W-1:0]   reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [fmag_pkg::RDATA_W-1:0]   reg_rdata,
  // element request from sequencer
  input  wire logic                           req_valid,
  input  wire fmag_pkg::fmag_coord_type       req_coord,
  // address answer
  output logic                                src_valid,
  output logic      [fmag_pkg::ADDR_W-1:0]    src_addr,
  output logic                                dst_valid,
  output logic      [fmag_pkg::ADDR_W-1:0]    dst_addr,
  output logic      [7:0]                     dst_bank,
  output logic                                addr_error
);
  localparam int AW = fmag_pkg::ADDR_W;
  localparam int DW = fmag_pkg::RDATA_W;
  // refuse pack depths that the four-bit bank index cannot serve
  if (PACK_DEPTH < 1 || PACK_DEPTH > 16) begin : g_depth_chk
    $error("PACK_DEPTH out of range");
  end

  // programmed state
  logic [DW-1:0] ctrl_q;
  logic [AW-1:0] src_feature_map_start_address_q, src_sy_q, src_sx_q, src_sc_q;
  logic [AW-1:0] dst_feature_map_start_address_q, dst_sy_q, dst_sx_q, dst_sc_q;
  logic [3:0]    kstride_q;
  logic [2:0]    sticky_q;

  wire wr_en = clk_en & reg_wr;
  wire rd_en = clk_en & reg_rd;
  wire esz2  = ctrl_q[fmag_pkg::CTRL_ESZ2];
  wire [fmag_pkg::CTRL_TILE_W-1:0] tile = ctrl_q[fmag_pkg::CTRL_TILE_LO +: fmag_pkg::CTRL_TILE_W];

  // register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q     <= fmag_pkg::CTRL_RESET;
      src_feature_map_start_address_q <= '0;
      src_sy_q   <= '0;
      src_sx_q   <= '0;
      src_sc_q   <= '0;
      dst_feature_map_start_address_q <= '0;
      dst_sy_q   <= '0;
      dst_sx_q   <= '0;
      dst_sc_q   <= '0;
      kstride_q  <= 4'h1;
    end else if (wr_en) begin
      case (reg_addr)
        fmag_pkg::REG_CTRL:     ctrl_q     <= reg_wdata;
        fmag_pkg::REG_SRC_FEATURE_MAP_START_ADDRESS: src_feature_map_start_address_q <= reg_wdata;
        fmag_pkg::REG_SRC_SY:   src_sy_q   <= reg_wdata;
        fmag_pkg::REG_SRC_SX:   src_sx_q   <= reg_wdata;
        fmag_pkg::REG_SRC_SC:   src_sc_q   <= reg_wdata;
        fmag_pkg::REG_DST_FEATURE_MAP_START_ADDRESS: dst_feature_map_start_address_q <= reg_wdata;
        fmag_pkg::REG_DST_SY:   dst_sy_q   <= reg_wdata;
        fmag_pkg::REG_DST_SX:   dst_sx_q   <= reg_wdata;
        fmag_pkg::REG_DST_SC:   dst_sc_q   <= reg_wdata;
        fmag_pkg::REG_KSTRIDE:  kstride_q  <= reg_wdata[3:0];
        default:                ;
      endcase
    end
  end

  // descriptors for both sides of the conversion
  wire fmag_pkg::fmag_map_type src_map = '{
    layout:   fmag_pkg::fmag_layout_type'(ctrl_q[fmag_pkg::CTRL_SRC_BLK]),
    feature_map_start_address:     src_feature_map_start_address_q,
    stride_y: src_sy_q,
    stride_x: src_sx_q,
    stride_c: src_sc_q};
  wire fmag_pkg::fmag_map_type dst_map = '{
    layout:   fmag_pkg::fmag_layout_type'(ctrl_q[fmag_pkg::CTRL_DST_BLK]),
    feature_map_start_address:     dst_feature_map_start_address_q,
    stride_y: dst_sy_q,
    stride_x: dst_sx_q,
    stride_c: dst_sc_q};

  // one address calculator per descriptor, source and destination, same coordinate
  wire [AW-1:0] src_a, dst_a;
  wire          src_mis, dst_mis;
  fmag_addr_calc u_src (
    .map        (src_map),
    .crd        (req_coord),
    .esz2       (esz2),
    .addr       (src_a),
    .misaligned (src_mis)
  );
  fmag_addr_calc u_dst (
    .map        (dst_map),
    .crd        (req_coord),
    .esz2       (esz2),
    .addr       (dst_a),
    .misaligned (dst_mis)
  );

  // only tile zero in interleaved layout; no batch input exists
  wire tile_err = (tile != '0) &
                  ((src_map.layout == fmag_pkg::LAYOUT_HWC) | (dst_map.layout == fmag_pkg::LAYOUT_HWC));
  wire req_err  = src_mis | dst_mis | tile_err;

  // bank from x over kernel stride, mod pack depth
  localparam int COORDW_F = fmag_pkg::COORD_W;
  wire [COORDW_F-1:0] xk;
  assign xk = (kstride_q == 4'h0) ? req_coord.x : COORDW_F'(req_coord.x / kstride_q);
  wire [7:0] bank_d = 8'(xk % PACK_DEPTH);

  // small pack bank holding last destination address of each slot
  logic [AW-1:0] pack_q [PACK_DEPTH];
  logic [fmag_pkg::BLK_SHIFT-1:0] ch_lo;
  assign ch_lo = req_coord.c[fmag_pkg::BLK_SHIFT-1:0];
  wire pack_flush = (ch_lo == 4'hF) | (dst_map.layout == fmag_pkg::LAYOUT_CB16);

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < PACK_DEPTH; i++) pack_q[i] <= '0;
    end else if (clk_en && req_valid && !req_err) begin
      pack_q[bank_d[3:0] % PACK_DEPTH] <= dst_a;
    end
  end

  // address outputs, registered
  always_ff @(posedge clk) begin
    if (rst) begin
      src_valid  <= 1'b0;
      src_addr   <= '0;
      dst_valid  <= 1'b0;
      dst_addr   <= '0;
      dst_bank   <= '0;
      addr_error <= 1'b0;
    end else if (clk_en) begin
      src_valid  <= req_valid & ~req_err;
      src_addr   <= src_a;
      dst_valid  <= req_valid & ~req_err & pack_flush;
      dst_addr   <= dst_a;
      dst_bank   <= bank_d;
      addr_error <= req_valid & req_err;
    end
  end

  // sticky error flags, set wins over clear-on-write
  wire [2:0] ev = {tile_err, dst_mis, src_mis} & {3{req_valid}};
  wire       st_clr = wr_en & (reg_addr == fmag_pkg::REG_STATUS);
  always_ff @(posedge clk) begin
    if (rst) sticky_q <= '0;
    else if (clk_en) sticky_q <= (sticky_q & ~(st_clr ? reg_wdata[2:0] : 3'h0)) | ev;
  end

  // read mux
  logic [DW-1:0] rmux;
  always_comb begin
    case (reg_addr)
      fmag_pkg::REG_CTRL:     rmux = ctrl_q;
      fmag_pkg::REG_SRC_FEATURE_MAP_START_ADDRESS: rmux = src_feature_map_start_address_q;
      fmag_pkg::REG_SRC_SY:   rmux = src_sy_q;
      fmag_pkg::REG_SRC_SX:   rmux = src_sx_q;
      fmag_pkg::REG_SRC_SC:   rmux = src_sc_q;
      fmag_pkg::REG_DST_FEATURE_MAP_START_ADDRESS: rmux = dst_feature_map_start_address_q;
      fmag_pkg::REG_DST_SY:   rmux = dst_sy_q;
      fmag_pkg::REG_DST_SX:   rmux = dst_sx_q;
      fmag_pkg::REG_DST_SC:   rmux = dst_sc_q;
      fmag_pkg::REG_STATUS:   rmux = {28'h0, src_valid, sticky_q};
      fmag_pkg::REG_KSTRIDE:  rmux = {28'h0, kstride_q};
      default:                rmux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) reg_rdata <= '0;
    else if (clk_en) reg_rdata <= rd_en ? rmux : 32'h0000_0000;
  end

  // checks
  property p_err_blocks;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && req_err) |=> (addr_error && !src_valid);
  endproperty
  a_err_blocks: assert property (p_err_blocks) else $error("bad request produced address");
  property p_cb_align;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && src_map.layout == fmag_pkg::LAYOUT_CB16
      && src_feature_map_start_address_q[3:0] != 4'h0) |=> addr_error;
  endproperty
  a_cb_align: assert property (p_cb_align) else $error("blocked misalignment missed");
  property p_tile0;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && tile != '0 && src_map.layout == fmag_pkg::LAYOUT_HWC)
      |=> !src_valid;
  endproperty
  a_tile0: assert property (p_tile0) else $error("nonzero tile accepted");
  property p_origin;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && req_coord == '0)
      |=> src_addr == $past(src_feature_map_start_address_q);
  endproperty
  a_origin: assert property (p_origin) else $error("origin not at feature_map_start_address");
  property p_esz;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && req_coord.y == 0 && req_coord.x == 0
      && req_coord.c == 1 && src_map.layout == fmag_pkg::LAYOUT_HWC)
      |=> src_addr == $past(src_feature_map_start_address_q) + (esz2 ? 2 : 1);
  endproperty
  a_esz: assert property (p_esz) else $error("element size scaling wrong");
  property p_blk16;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && req_coord.y == 0 && req_coord.x == 0
      && req_coord.c == 16 && src_map.layout == fmag_pkg::LAYOUT_CB16)
      |=> src_addr == $past(src_feature_map_start_address_q) + $past(src_sc_q);
  endproperty
  a_blk16: assert property (p_blk16) else $error("channel block step wrong");
  property p_sticky;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && src_mis) |=> sticky_q[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("source flag lost");
  property p_rd;
    @(posedge clk) disable iff (rst) (clk_en && !reg_rd) |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside read");

  // refused descriptors raise the error pulse and the sticky flags; a status write clears a flag
  property p_hwc_align;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && src_map.layout == fmag_pkg::LAYOUT_HWC && esz2
      && src_feature_map_start_address_q[0]) |=> (addr_error && !src_valid && sticky_q[fmag_pkg::ST_SRC_ALIGN]);
  endproperty
  a_hwc_align: assert property (p_hwc_align) else $error("odd interleaved feature_map_start_address accepted");
  property p_src_sy_flag;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && src_map.layout == fmag_pkg::LAYOUT_CB16
      && src_sy_q[3:0] != 4'h0) |=> (addr_error && sticky_q[fmag_pkg::ST_SRC_ALIGN]);
  endproperty
  a_src_sy_flag: assert property (p_src_sy_flag) else $error("blocked row stride misalignment missed");
  property p_dst_flag;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && dst_map.layout == fmag_pkg::LAYOUT_CB16
      && dst_feature_map_start_address_q[3:0] != 4'h0) |=> (addr_error && !dst_valid && sticky_q[fmag_pkg::ST_DST_ALIGN]);
  endproperty
  a_dst_flag: assert property (p_dst_flag) else $error("blocked destination misalignment missed");
  property p_tile_flag;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && tile != '0
      && (src_map.layout == fmag_pkg::LAYOUT_HWC || dst_map.layout == fmag_pkg::LAYOUT_HWC))
      |=> (addr_error && !dst_valid && sticky_q[fmag_pkg::ST_TILE_ERR]);
  endproperty
  a_tile_flag: assert property (p_tile_flag) else $error("nonzero tile not flagged");
  property p_clr;
    @(posedge clk) disable iff (rst) (clk_en && st_clr && reg_wdata[fmag_pkg::ST_SRC_ALIGN]
      && !(req_valid && src_mis)) |=> !sticky_q[fmag_pkg::ST_SRC_ALIGN];
  endproperty
  a_clr: assert property (p_clr) else $error("source flag not cleared");

  // blocked address from split channel, one-byte elements
  property p_chsplit;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && !esz2
      && src_map.layout == fmag_pkg::LAYOUT_CB16)
      |=> src_addr == $past(src_feature_map_start_address_q) + $past(src_sy_q) * 32'($past(req_coord.y))
        + $past(src_sc_q) * 32'($past(req_coord.c) >> 4)
        + 32'($past(req_coord.x)) * 32'h10 + 32'($past(req_coord.c[3:0]));
  endproperty
  a_chsplit: assert property (p_chsplit) else $error("channel split wrong");
  property p_origin_dst;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && req_coord == '0)
      |=> dst_addr == $past(dst_feature_map_start_address_q);
  endproperty
  a_origin_dst: assert property (p_origin_dst) else $error("destination origin not at feature_map_start_address");

  // pack bank slot, bank choice and flush timing
  property p_pack;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err)
      |=> pack_q[$past(bank_d[3:0]) % PACK_DEPTH] == $past(dst_a);
  endproperty
  a_pack: assert property (p_pack) else $error("pack slot not loaded");
  property p_hwc_hold;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && dst_map.layout == fmag_pkg::LAYOUT_HWC
      && req_coord.c[3:0] != 4'hF) |=> !dst_valid;
  endproperty
  a_hwc_hold: assert property (p_hwc_hold) else $error("interleaved store before channel group end");
  property p_cb_dst;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && !req_err && dst_map.layout == fmag_pkg::LAYOUT_CB16)
      |=> dst_valid;
  endproperty
  a_cb_dst: assert property (p_cb_dst) else $error("blocked store missing");
  property p_bank;
    @(posedge clk) disable iff (rst) (clk_en && req_valid && kstride_q != 4'h0)
      |=> 32'(dst_bank) == (32'($past(req_coord.x)) / 32'($past(kstride_q))) % PACK_DEPTH;
  endproperty
  a_bank: assert property (p_bank) else $error("bank choice ignores kernel stride");

  // main scenarios
  c_cb_ok:  cover property (@(posedge clk) src_valid && ctrl_q[fmag_pkg::CTRL_SRC_BLK]);
  c_conv:   cover property (@(posedge clk) dst_valid && !ctrl_q[fmag_pkg::CTRL_DST_BLK]);
  c_err:    cover property (@(posedge clk) addr_error);
  c_tile:   cover property (@(posedge clk) src_valid && tile != '0);
  c_b2b:    cover property (@(posedge clk) src_valid ##1 src_valid);
endmodule

// File: tb/fmag_mem_model.sv
`timescale 1ns/1ps
module fmag_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // address strobes from the generator
  input  wire logic        rd_valid,
  input  wire logic        wr_valid,
  // access counts
  output logic      [15:0] rd_count,
  output logic      [15:0] wr_count
);
  // count fetches and stores reaching memory
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_count <= 16'h0000;
      wr_count <= 16'h0000;
    end else begin
      rd_count <= rd_count + {15'h0000, rd_valid};
      wr_count <= wr_count + {15'h0000, wr_valid};
    end
  end
endmodule

// File: tb/fmag_top_tb.sv
`timescale 1ns/1ps
module fmag_top_tb;
  typedef struct packed {logic [31:0] ctrl; logic [15:0] y; logic [15:0] x; logic [15:0] c;} fmag_row_type;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     clk_en = 1'b1;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic                     req_valid = 1'b0;
  logic [3:0]               reg_addr = 4'h0;
  logic [31:0]              reg_wdata = 32'h0;
  logic [31:0]              reg_rdata, src_addr, dst_addr, rd;
  fmag_pkg::fmag_coord_type req_coord = '0;
  logic                     src_valid, dst_valid, addr_error;
  logic [7:0]               dst_bank;
  logic [15:0]              rd_count, wr_count;
  int                       miscompares = 0;
  int                       checked = 0;
  int                       exp_rd = 0;
  int                       exp_wr = 0;
  // aligned descriptors: src feature_map_start_address,row,col,block then dst
  logic [31:0] cfg [1:8] = '{32'h1000, 32'h100, 32'h20, 32'h400, 32'h8000, 32'h200, 32'h40, 32'h800};
  // ctrl and coordinate per case
  fmag_row_type rows [8] = '{'{32'h2, 16'h0, 16'h0, 16'h0}, '{32'h2, 16'h3, 16'h5, 16'h11},
    '{32'h6, 16'h2, 16'h1, 16'hF}, '{32'h5, 16'h1, 16'h2, 16'hF}, '{32'h1, 16'h0, 16'h3, 16'h1F},
    '{32'h1, 16'h4, 16'h6, 16'hE}, '{32'h13, 16'h1, 16'h1, 16'h10}, '{32'h13, 16'h2, 16'h9, 16'h2F}};

  // clock
  always #10 clk = ~clk;

  fmag_top #(.PACK_DEPTH(4)) dut_u (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_coord(req_coord), .src_valid(src_valid), .src_addr(src_addr), .dst_valid(dst_valid),
    .dst_addr(dst_addr), .dst_bank(dst_bank), .addr_error(addr_error));
  fmag_mem_model mem_u (.clk(clk), .rst(rst), .rd_valid(src_valid), .wr_valid(dst_valid),
    .rd_count(rd_count), .wr_count(wr_count));

  // helpers
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask
  task automatic send(input fmag_row_type r);
    @(posedge clk);
    req_valid <= 1'b1;
    req_coord <= '{r.y, r.x, r.c};
  endtask
  function automatic logic [31:0] lay(input logic blk, input logic [31:0] b, sy, sx, sc, e, input fmag_row_type r);
    if (blk) begin
      return b + r.y * sy + 32'(r.c >> 4) * sc + (r.x * 32'h10 + 32'(r.c[3:0])) * e;
    end
    return b + r.y * sy + r.x * sx + r.c * e;
  endfunction
  task automatic chk(input fmag_row_type r);
    logic [31:0] e;
    logic        dv;
    e = r.ctrl[2] ? 32'h2 : 32'h1;
    dv = r.ctrl[1] | (r.c[3:0] == 4'hF);
    cmp("src_valid", 32'h1, src_valid);
    cmp("addr_error", 32'h0, addr_error);
    cmp("src_addr", lay(r.ctrl[0], cfg[1], cfg[2], cfg[3], cfg[4], e, r), src_addr);
    cmp("dst_valid", dv, dst_valid);
    if (dv) begin
      cmp("dst_addr", lay(r.ctrl[1], cfg[5], cfg[6], cfg[7], cfg[8], e, r), dst_addr);
      cmp("dst_bank", 32'((r.x / 2) % 4), dst_bank);
      exp_wr++;
    end
    exp_rd++;
  endtask
  task automatic bad(input logic [31:0] ctrl, input logic [3:0] a, input logic [31:0] v, input int bi);
    wr(fmag_pkg::REG_CTRL, ctrl);
    wr(a, v);
    send('{ctrl, 16'h1, 16'h1, 16'h1});
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    cmp("addr_error", 32'h1, addr_error);
    cmp("src_valid", 32'h0, src_valid);
    rdr(fmag_pkg::REG_STATUS);
    cmp("status_set", 32'h1, rd[bi]);
    wr(fmag_pkg::REG_STATUS, 32'h1 << bi);
    rdr(fmag_pkg::REG_STATUS);
    cmp("status_clr", 32'h0, rd[bi]);
    wr(a, cfg[a]);
  endtask

  // watchdog
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp("rst_src_valid", 32'h0, src_valid);
    cmp("rst_dst_valid", 32'h0, dst_valid);
    cmp("rst_rdata", 32'h0, reg_rdata);
    rdr(fmag_pkg::REG_CTRL);
    cmp("ctrl_reset", fmag_pkg::CTRL_RESET, rd);
    rdr(fmag_pkg::REG_KSTRIDE);
    cmp("kstride_reset", 32'h1, rd);
    wr(4'hF, 32'hFFFF_FFFF);
    rdr(fmag_pkg::REG_CTRL);
    cmp("ctrl_unmapped", 32'h0, rd);
    for (int k = 1; k < 9; k++) begin
      wr(4'(k), cfg[k]);
    end
    wr(fmag_pkg::REG_KSTRIDE, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(fmag_pkg::REG_CTRL, rows[i].ctrl);
      rdr(fmag_pkg::REG_CTRL);
      cmp("ctrl", rows[i].ctrl, rd);
      send(rows[i]);
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      chk(rows[i]);
    end
    // back to back requests
    send(rows[6]);
    send(rows[7]);
    @(negedge clk);
    chk(rows[6]);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk(rows[7]);
    // frozen clock enable ignores a request
    @(posedge clk);
    clk_en <= 1'b0;
    req_valid <= 1'b1;
    @(posedge clk);
    clk_en <= 1'b1;
    req_valid <= 1'b0;
    @(negedge clk);
    cmp("frozen_src_valid", 32'h0, src_valid);
    // refused descriptors
    bad(32'h6, fmag_pkg::REG_SRC_FEATURE_MAP_START_ADDRESS, 32'h1001, fmag_pkg::ST_SRC_ALIGN);
    bad(32'h1, fmag_pkg::REG_SRC_SY, 32'h108, fmag_pkg::ST_SRC_ALIGN);
    bad(32'h3, fmag_pkg::REG_DST_FEATURE_MAP_START_ADDRESS, 32'h8008, fmag_pkg::ST_DST_ALIGN);
    bad(32'h12, fmag_pkg::REG_SRC_FEATURE_MAP_START_ADDRESS, cfg[1], fmag_pkg::ST_TILE_ERR);
    repeat (2) @(negedge clk);
    cmp("mem_reads", 32'(exp_rd), rd_count);
    cmp("mem_writes", 32'(exp_wr), wr_count);
    // reset in mid-run with a request pending
    send(rows[0]);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    req_valid <= 1'b0;
    @(negedge clk);
    cmp("rst2_src_valid", 32'h0, src_valid);
    cmp("rst2_dst_valid", 32'h0, dst_valid);
    cmp("rst2_addr_error", 32'h0, addr_error);
    cmp("rst2_src_addr", 32'h0, src_addr);
    cmp("rst2_dst_bank", 32'h0, dst_bank);
    rdr(fmag_pkg::REG_SRC_FEATURE_MAP_START_ADDRESS);
    cmp("rst2_src_feature_map_start_address", 32'h0, rd);
    print_verdict();
  end
endmodule
